// >>> common/adc_mode_cfg.svh
/*
  Offsets, field positions, masks, codes and reset values of the mode configuration port.
  Assumes it is included by bare name wherever these constants are used.
*/
`ifndef ADC_MODE_CFG_SVH
`define ADC_MODE_CFG_SVH
`define REG_SOFT_RESET_ADDR 7'h00
`define REG_POWER_DOWN_ADDR 7'h01
`define REG_CLOCK_TIMING_ADDR 7'h02
`define REG_DRIVER_MODE_ADDR 7'h03
`define REG_DATA_FORMAT_ADDR 7'h04
`define MODE_REG_RESET 8'h00
`define SOFT_RESET_BIT 7
`define POWER_DOWN_MASK 8'h03
`define CLOCK_TIMING_MASK 8'h0f
`define DRIVER_MODE_MASK 8'h7f
`define DATA_FORMAT_MASK 8'h3f
`define POWER_NORMAL 2'h0
`define POWER_SLEEP 2'h3
`define FORMAT_FULL_CMOS 2'h0
`define FORMAT_DDR_LVDS 2'h1
`define TEST_ZEROS 3'h1
`define TEST_ONES 3'h3
`define TEST_CHECKER 3'h5
`define TEST_ALTERNATE 3'h7
`define CHECKER_WORD_A 17'h1_5555
`define CHECKER_WORD_B 17'h0_aaaa
`define ODD_BIT_MASK 16'haaaa
`define SER_WORD_LEN 5'h10
`define SER_HEADER_LEN 5'h08
`define SYNC_RESET_PINS 5'h08
`endif

// >>> common/adc_mode_pkg.sv
/*
  Types shared by the mode configuration port and its helpers.
  Assumes nothing of its surroundings.
*/
package adc_mode_pkg;
  typedef enum logic [1:0] {SER_IDLE, SER_SHIFT, SER_HOLD} serial_state_t;
  typedef logic [1:0] power_state_t;
  typedef logic [7:0] mode_byte_t;
  typedef logic [6:0] reg_addr_t;
endpackage

// >>> core/pin_sync.sv
/*
  Two flip-flop synchroniser for a group of pins.
  Assumes each bit is an independent level from outside the clock domain.
*/
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins in, synchronised levels out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= RST_VAL;
      sync_o <= RST_VAL;
    end
    else
    begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule

// >>> core/data_formatter.sv
/*
  Output word formatting: signed format unless odd bit inversion is on, scrambling, odd bit inversion and test patterns.
  Assumes samples arrive as offset binary words on the same clock with a one-cycle valid.
*/
`timescale 1ns/100ps
`include "adc_mode_cfg.svh"
module data_formatter
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Raw samples
  input wire logic sample_valid_i,
  input wire logic [15:0] sample_i,
  input wire logic overrange_i,
  // Format controls
  input wire logic [2:0] test_pattern_select_i,
  input wire logic odd_bit_invert_enable_i,
  input wire logic output_scrambler_enable_i,
  input wire logic signed_format_select_i,
  // Formatted samples
  output logic data_valid_o,
  output logic [15:0] data_o,
  output logic overrange_flag_o
);
  logic phase_reg;
  logic [15:0] word;
  logic [16:0] out_next;

  // Formatting chain; a test pattern overrides everything
  always_comb
  begin
    word = sample_i;
    if (signed_format_select_i && !odd_bit_invert_enable_i)
      word[15] = ~word[15];
    if (output_scrambler_enable_i)
      word[15:1] = word[15:1] ^ {15{word[0]}};
    if (odd_bit_invert_enable_i)
      word = word ^ `ODD_BIT_MASK;
    out_next = {overrange_i, word};
    case (test_pattern_select_i)
      `TEST_ZEROS: out_next = '0;
      `TEST_ONES: out_next = '1;
      `TEST_CHECKER: out_next = phase_reg ? `CHECKER_WORD_B : `CHECKER_WORD_A;
      `TEST_ALTERNATE: out_next = phase_reg ? '1 : '0;
      default: ;
    endcase
  end

  // Output register and alternating-pattern phase
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phase_reg <= 1'b0;
      data_valid_o <= 1'b0;
      data_o <= 16'h0000;
      overrange_flag_o <= 1'b0;
    end
    else
    begin
      data_valid_o <= sample_valid_i;
      if (sample_valid_i)
      begin
        phase_reg <= ~phase_reg;
        {overrange_flag_o, data_o} <= out_next;
      end
    end
  end

  chk_pattern_zero_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_valid_i && test_pattern_select_i == `TEST_ZEROS |=> data_o == 16'h0000 && !overrange_flag_o)
    else $error("zero pattern did not override the sample");
  chk_odd_bits_flip: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_valid_i && test_pattern_select_i == 3'h0 && odd_bit_invert_enable_i && !output_scrambler_enable_i
    |=> data_o == ($past(sample_i) ^ `ODD_BIT_MASK))
    else $error("odd bit inversion wrong");
endmodule

// >>> core/adc_mode_config_port.sv
/*
  Mode configuration port: strap decode in parallel mode, serial register port in serial mode,
  five mode control registers, open-drain read-back and the output word formatter.
  Assumes a host drives chip select, serial clock and data in; the serial clock is far slower
  than clk_i and is sampled like any other pin. Samples come from logic on clk_i.
*/
`timescale 1ns/100ps
`include "adc_mode_cfg.svh"

module adc_mode_config_port
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Configuration pins
  input wire logic interface_select_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic sdi_i,
  input wire logic sdo_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // Converter samples
  input wire logic sample_valid_i,
  input wire logic [15:0] sample_i,
  input wire logic overrange_i,
  output logic data_valid_o,
  output logic [15:0] data_o,
  output logic overrange_flag_o,
  output logic data_oe_o,
  // Mode controls
  output adc_mode_pkg::power_state_t power_state_o,
  output logic duty_cycle_stabilizer_on_o,
  output logic sample_clock_invert_o,
  output logic [1:0] sample_clock_delay_field_o,
  output logic [2:0] driver_current_field_o,
  output logic internal_termination_enable_o,
  output logic output_disable_o,
  output logic [1:0] output_format_select_o
);
  import adc_mode_pkg::*;

  logic [4:0] pins_s;
  logic sel_s, cs_s, sck_s, sdi_s, sdo_s;
  logic serial_mode;
  logic sck_prev_reg, cs_prev_reg;
  logic sck_rise, sck_fall, cs_fall, cs_rise;
  serial_state_t state_reg;
  logic [4:0] bit_cnt_reg;
  logic [14:0] shift_reg;
  logic [15:0] full_word;
  logic word_done, write_done, soft_reset_set;
  logic soft_reset_reg;
  mode_byte_t power_reg, timing_reg, driver_reg, format_reg;
  reg_addr_t read_addr;
  mode_byte_t read_data;
  logic read_start, read_active_reg;
  mode_byte_t sdo_shift_reg;
  logic sdo_oe_reg;
  mode_byte_t format_cfg;
  power_state_t power_next;
  logic dcs_next, invert_next, term_next, disable_next;
  logic [1:0] delay_next, outfmt_next;
  logic [2:0] current_next;

  // All pins pass two flip-flops; chip select idles high
  pin_sync #(.WIDTH(5), .RST_VAL(`SYNC_RESET_PINS)) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({interface_select_i, cs_n_i, sck_i, sdi_i, sdo_i}),
    .sync_o(pins_s)
  );

  assign {sel_s, cs_s, sck_s, sdi_s, sdo_s} = pins_s;
  assign serial_mode = ~sel_s;

  // Previous levels for edge detection
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sck_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end
    else
    begin
      sck_prev_reg <= sck_s;
      cs_prev_reg <= cs_s;
    end
  end

  // Edges of the serial clock and chip select
  assign sck_rise = sck_s & ~sck_prev_reg;
  assign sck_fall = ~sck_s & sck_prev_reg;
  assign cs_fall = ~cs_s & cs_prev_reg;
  assign cs_rise = cs_s & ~cs_prev_reg;

  // Transfer sequencer: counts the first sixteen rising clocks, then holds
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !serial_mode || cs_rise)
    begin
      state_reg <= SER_IDLE;
      bit_cnt_reg <= 5'h00;
    end
    else
    begin
      unique case (state_reg)
        SER_IDLE:
        begin
          if (cs_fall)
          begin
            state_reg <= SER_SHIFT;
            bit_cnt_reg <= 5'h00;
          end
        end
        SER_SHIFT:
        begin
          if (sck_rise)
          begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == `SER_WORD_LEN - 5'h01)
              state_reg <= SER_HOLD;
          end
        end
        SER_HOLD: ;  // Further rising clocks are ignored until chip select rises
        default: state_reg <= SER_IDLE;
      endcase
    end
  end

  // Input shift register, MSB first
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      shift_reg <= 15'h0000;
    else if (state_reg == SER_SHIFT && sck_rise)
      shift_reg <= {shift_reg[13:0], sdi_s};
  end

  // Completed word: flag, address, data
  assign full_word = {shift_reg, sdi_s};
  assign word_done = state_reg == SER_SHIFT && sck_rise && bit_cnt_reg == `SER_WORD_LEN - 5'h01;
  assign write_done = word_done && !full_word[15];
  assign soft_reset_set = write_done && full_word[14:8] == `REG_SOFT_RESET_ADDR
    && full_word[`SOFT_RESET_BIT];

  // Mode control registers; unused bits and undefined addresses are dropped
  always_ff @(posedge clk_i)
  begin
    if (rst_i || soft_reset_set)
    begin
      power_reg <= `MODE_REG_RESET;
      timing_reg <= `MODE_REG_RESET;
      driver_reg <= `MODE_REG_RESET;
      format_reg <= `MODE_REG_RESET;
    end
    else if (write_done)
    begin
      case (full_word[14:8])
        `REG_POWER_DOWN_ADDR: power_reg <= full_word[7:0] & `POWER_DOWN_MASK;
        `REG_CLOCK_TIMING_ADDR: timing_reg <= full_word[7:0] & `CLOCK_TIMING_MASK;
        `REG_DRIVER_MODE_ADDR: driver_reg <= full_word[7:0] & `DRIVER_MODE_MASK;
        `REG_DATA_FORMAT_ADDR: format_reg <= full_word[7:0] & `DATA_FORMAT_MASK;
        default: ;
      endcase
    end
  end

  // Software reset stays set until the write ends; a new set wins over the clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      soft_reset_reg <= 1'b0;
    else if (soft_reset_set)
      soft_reset_reg <= 1'b1;
    else if (cs_rise || !serial_mode)
      soft_reset_reg <= 1'b0;
  end

  // Read-back selection; the reset register and unmapped addresses read zero
  assign read_addr = {shift_reg[5:0], sdi_s};
  always_comb
  begin
    case (read_addr)
      `REG_POWER_DOWN_ADDR: read_data = power_reg;
      `REG_CLOCK_TIMING_ADDR: read_data = timing_reg;
      `REG_DRIVER_MODE_ADDR: read_data = driver_reg;
      `REG_DATA_FORMAT_ADDR: read_data = format_reg;
      default: read_data = `MODE_REG_RESET;
    endcase
  end

  // Read starts at the eighth rising clock when the flag is set
  assign read_start = state_reg == SER_SHIFT && sck_rise && bit_cnt_reg == `SER_HEADER_LEN - 5'h01
    && shift_reg[6];

  // Output shifter: D7 is presented at once, later bits after each of the ninth to fifteenth falling clocks
  always_ff @(posedge clk_i)
  begin
    if (rst_i || cs_rise || !serial_mode)
    begin
      read_active_reg <= 1'b0;
      sdo_shift_reg <= 8'h00;
    end
    else if (read_start)
    begin
      read_active_reg <= 1'b1;
      sdo_shift_reg <= read_data;
    end
    else if (read_active_reg && sck_fall && bit_cnt_reg > `SER_HEADER_LEN && bit_cnt_reg < `SER_WORD_LEN)
      sdo_shift_reg <= {sdo_shift_reg[6:0], 1'b0};
  end

  // Open-drain driver: pull low for a zero, release for a one; silent in strap mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sdo_oe_reg <= 1'b0;
    else
      sdo_oe_reg <= serial_mode && read_active_reg && !sdo_shift_reg[7];
  end
  assign sdo_o = 1'b0;
  assign sdo_oe_o = sdo_oe_reg;

  // Effective modes from straps or registers
  always_comb
  begin
    if (!serial_mode)
    begin
      power_next = {sdi_s, sdo_s};
      dcs_next = cs_s;
      invert_next = 1'b0;
      delay_next = 2'h0;
      current_next = 3'h0;
      term_next = 1'b0;
      disable_next = 1'b0;
      outfmt_next = sck_s ? `FORMAT_DDR_LVDS : `FORMAT_FULL_CMOS;
      format_cfg = `MODE_REG_RESET;
    end
    else
    begin
      power_next = soft_reset_reg ? `POWER_SLEEP : power_reg[1:0];
      dcs_next = timing_reg[0];
      invert_next = timing_reg[3];
      delay_next = timing_reg[2:1];
      current_next = driver_reg[6:4];
      term_next = driver_reg[3];
      disable_next = driver_reg[2];
      outfmt_next = driver_reg[1:0];
      format_cfg = format_reg;
    end
  end

  // Registered mode outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      power_state_o <= `POWER_NORMAL;
      duty_cycle_stabilizer_on_o <= 1'b0;
      sample_clock_invert_o <= 1'b0;
      sample_clock_delay_field_o <= 2'h0;
      driver_current_field_o <= 3'h0;
      internal_termination_enable_o <= 1'b0;
      output_disable_o <= 1'b0;
      output_format_select_o <= `FORMAT_FULL_CMOS;
      data_oe_o <= 1'b0;
    end
    else
    begin
      power_state_o <= power_next;
      duty_cycle_stabilizer_on_o <= dcs_next;
      sample_clock_invert_o <= invert_next;
      sample_clock_delay_field_o <= delay_next;
      driver_current_field_o <= current_next;
      internal_termination_enable_o <= term_next;
      output_disable_o <= disable_next;
      output_format_select_o <= outfmt_next;
      data_oe_o <= !disable_next;
    end
  end

  // Output word formatter
  data_formatter u_data_formatter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sample_valid_i(sample_valid_i),
    .sample_i(sample_i),
    .overrange_i(overrange_i),
    .test_pattern_select_i(format_cfg[5:3]),
    .odd_bit_invert_enable_i(format_cfg[2]),
    .output_scrambler_enable_i(format_cfg[1]),
    .signed_format_select_i(format_cfg[0]),
    .data_valid_o(data_valid_o),
    .data_o(data_o),
    .overrange_flag_o(overrange_flag_o)
  );
  sequence power_write_s;
    write_done && full_word[14:8] == `REG_POWER_DOWN_ADDR;
  endsequence
  sequence read_request_s;
    read_start ##1 !cs_rise && serial_mode;
  endsequence
  chk_strap_power_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_s |=> power_state_o == $past({sdi_s, sdo_s}))
    else $error("strap power state wrong");
  chk_strap_stabilizer: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_s |=> duty_cycle_stabilizer_on_o == $past(cs_s) && !sdo_oe_o)
    else $error("strap stabiliser or sdo wrong");
  chk_strap_out_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_s && sck_s |=> output_format_select_o == `FORMAT_DDR_LVDS && driver_current_field_o == 3'h0
    && !internal_termination_enable_o)
    else $error("strap output mode wrong");
  chk_power_write_data: assert property (@(posedge clk_i) disable iff (rst_i)
    power_write_s |=> power_reg == ($past(full_word[7:0]) & `POWER_DOWN_MASK))
    else $error("power register write lost");
  chk_read_keeps_regs: assert property (@(posedge clk_i) disable iff (rst_i)
    word_done && full_word[15] |=> $stable(power_reg) && $stable(timing_reg) && $stable(driver_reg)
    && $stable(format_reg))
    else $error("read changed a register");
  chk_read_first_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    read_request_s |=> sdo_oe_o == !$past(read_data[7], 2))
    else $error("first read bit wrong");
  chk_soft_reset_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    soft_reset_set |=> power_reg == 8'h00 && timing_reg == 8'h00 && soft_reset_reg ##1 power_state_o == `POWER_SLEEP)
    else $error("soft reset did not clear or sleep");
  chk_soft_reset_ends: assert property (@(posedge clk_i) disable iff (rst_i)
    soft_reset_reg && cs_rise && !soft_reset_set |=> !soft_reset_reg)
    else $error("soft reset did not self-clear");
  chk_extra_edges_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == SER_HOLD && sck_rise |=> $stable(shift_reg) && bit_cnt_reg == `SER_WORD_LEN)
    else $error("edge after sixteen captured");
  chk_timing_fields: assert property (@(posedge clk_i) disable iff (rst_i)
    serial_mode |=> sample_clock_delay_field_o == $past(timing_reg[2:1])
    && sample_clock_invert_o == $past(timing_reg[3]))
    else $error("timing fields not applied");
endmodule

// >>> dv/cfg_host.sv
/*
  Host model of the serial mode port: drives chip select, serial clock and data in, reads SDO.
  Assumes clk_i is the device clock and sdo_i is the pulled-up SDO wire level.
*/
`timescale 1ns/100ps
module cfg_host
(
  // Clock and SDO wire
  input wire logic clk_i,
  input wire logic sdo_i,
  // Serial pins
  output logic cs_n_o,
  output logic sck_o,
  output logic sdi_o
);
  // Idle levels; the serial clock stands low outside frames
  initial
  begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end
  // One frame of nbits clocks, 8 clk_i each; bits 9 to 16 of SDO land in rd
  task automatic xfer(input logic [15:0] word, input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk_i) cs_n_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < nbits; i++)
    begin
      @(posedge clk_i) sdi_o <= (i < 16) ? word[15 - i] : ~sdi_o;
      repeat (3) @(posedge clk_i);
      sck_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      // Sampled late in the high phase, well after the device moved SDO
      if (i >= 8 && i < 16)
        rd = {rd[6:0], sdo_i};
      @(posedge clk_i) sck_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    repeat (6) @(posedge clk_i);
  endtask
endmodule

// >>> dv/adc_mode_config_port_tb.sv
/*
  Self-checking bench of the mode configuration port: serial registers, straps, sample formatting.
  Assumes the cfg_host model drives the serial pins and SDO has a pull-up.
*/
`timescale 1ns/100ps
`include "adc_mode_cfg.svh"
module adc_mode_config_port_tb;
  import adc_mode_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sel = 1'b0;
  logic [3:0] strap = 4'h8;
  logic sv = 1'b0;
  logic [15:0] smp = 16'h0000;
  logic ovr = 1'b0;
  logic h_cs, h_sck, h_sdi, sdo_o, sdo_oe_o, dv_o, of_o, oe_o, dcs_o, inv_o, term_o, dis_o, sdo_pin;
  logic [15:0] data_o;
  power_state_t pwr_o;
  logic [1:0] dly_o, fmt_o;
  logic [2:0] cur_o;
  logic [16:0] mode_now;
  logic [7:0] sh [0:4] = '{default: 8'h00};
  logic [16:0] q [$];
  int errors = 0;
  int total_checks = 0;
  int ph = 0;
  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;
  // SDO wire: strap level in parallel mode, else pulled up unless the device pulls low
  assign sdo_pin = sel ? strap[0] : ~sdo_oe_o;
  // SDO data level must stay low; only its enable moves
  assign mode_now = {1'b0, sdo_o, sdo_oe_o, pwr_o, dcs_o, inv_o, dly_o, cur_o, term_o, dis_o, fmt_o, oe_o};
  cfg_host host (.clk_i(clk_i), .sdo_i(sdo_pin), .cs_n_o(h_cs), .sck_o(h_sck), .sdi_o(h_sdi));
  adc_mode_config_port dut (
    .clk_i(clk_i), .rst_i(rst_i), .interface_select_i(sel),
    .cs_n_i(sel ? strap[3] : h_cs), .sck_i(sel ? strap[2] : h_sck), .sdi_i(sel ? strap[1] : h_sdi),
    .sdo_i(sdo_pin), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .sample_valid_i(sv), .sample_i(smp),
    .overrange_i(ovr), .data_valid_o(dv_o), .data_o(data_o), .overrange_flag_o(of_o), .data_oe_o(oe_o),
    .power_state_o(pwr_o), .duty_cycle_stabilizer_on_o(dcs_o), .sample_clock_invert_o(inv_o),
    .sample_clock_delay_field_o(dly_o), .driver_current_field_o(cur_o),
    .internal_termination_enable_o(term_o), .output_disable_o(dis_o), .output_format_select_o(fmt_o));
  // Compare and count
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic end_sim;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Writable bits of each register
  function automatic logic [7:0] msk(input logic [6:0] a);
    case (a)
      7'h01: return `POWER_DOWN_MASK;
      7'h02: return `CLOCK_TIMING_MASK;
      7'h03: return `DRIVER_MODE_MASK;
      7'h04: return `DATA_FORMAT_MASK;
      default: return 8'h00;
    endcase
  endfunction
  // Expected formatted word for one sample
  function automatic logic [16:0] fmt(input logic [15:0] s, input logic o, input logic [7:0] f, input int p);
    logic [15:0] v;
    v = s;
    case (f[5:3])
      `TEST_ZEROS: return 17'h0_0000;
      `TEST_ONES: return 17'h1_ffff;
      `TEST_CHECKER: return (p != 0) ? `CHECKER_WORD_B : `CHECKER_WORD_A;
      `TEST_ALTERNATE: return (p != 0) ? 17'h1_ffff : 17'h0_0000;
      default: ;
    endcase
    if (f[0] && !f[2])
      v[15] = ~v[15];
    if (f[1])
      v[15:1] = v[15:1] ^ {15{v[0]}};
    if (f[2])
      v = v ^ `ODD_BIT_MASK;
    return {o, v};
  endfunction
  // Serial write; shadow follows unless the frame is cut short
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n = 16);
    logic [7:0] rd;
    host.xfer({1'b0, a, d}, n, rd);
    if (n < 16)
      return;
    if (a == `REG_SOFT_RESET_ADDR && d[`SOFT_RESET_BIT])
      sh = '{default: `MODE_REG_RESET};
    else if (a > 7'h00 && a < 7'h05)
      sh[a] = d & msk(a);
  endtask
  // Serial read with all-ones data bits, compared with the shadow
  task automatic rdck(input logic [6:0] a);
    logic [7:0] rd;
    host.xfer({1'b1, a, 8'hff}, 16, rd);
    check({9'h000, rd}, {9'h000, (a < 7'h05) ? sh[a] : 8'h00});
  endtask
  // Mode outputs against the shadow; SDO released
  task automatic modeck;
    check(mode_now, {3'h0, sh[1][1:0], sh[2][0], sh[2][3], sh[2][2:1], sh[3][6:4], sh[3][3], sh[3][2],
      sh[3][1:0], ~sh[3][2]});
  endtask
  // Four spaced samples under one format setting
  task automatic samples(input logic [7:0] f);
    logic [15:0] s;
    logic o;
    wr(`REG_DATA_FORMAT_ADDR, f);
    repeat (4)
    begin
      s = 16'($urandom);
      o = 1'($urandom);
      q.push_back(fmt(s, o, sh[4], ph % 2));
      ph++;
      @(posedge clk_i);
      sv <= 1'b1;
      smp <= s;
      ovr <= o;
      @(posedge clk_i);
      sv <= 1'b0;
    end
  endtask
  // Each formatted sample against the oldest expectation
  always @(posedge clk_i)
  begin
    if (dv_o === 1'b1)
    begin
      // A result with no expectation always counts as a mismatch
      if (q.size() == 0)
        check(17'h0_0000, 17'h0_0001);
      else
        check({of_o, data_o}, q.pop_front());
    end
  end
  // Hang guard
  initial
  begin
    repeat (40000) @(posedge clk_i);
    check(17'h0_0000, 17'h0_0001);
    end_sim;
  end
  // Main sequence
  initial
  begin
    logic [7:0] d;
    void'($urandom(32'hb5c5));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    modeck;
    wr(`REG_SOFT_RESET_ADDR, 8'h80);
    modeck;
    rdck(`REG_SOFT_RESET_ADDR);
    $display("test reset done");
    for (int k = 0; k < 15; k++)
    begin
      d = 8'($urandom);
      if (d[2:1] != 2'h0)
        d[0] = 1'b1;
      wr(7'(k % 5 + 1), d);
      rdck(7'(k % 5 + 1));
      modeck;
    end
    $display("test registers done");
    wr(`REG_POWER_DOWN_ADDR, ~sh[1], 10);
    rdck(`REG_POWER_DOWN_ADDR);
    wr(`REG_CLOCK_TIMING_ADDR, 8'h0b, 18);
    rdck(`REG_CLOCK_TIMING_ADDR);
    wr(`REG_SOFT_RESET_ADDR, 8'hff);
    for (int a = 1; a < 5; a++)
      rdck(7'(a));
    modeck;
    $display("test frames done");
    sel <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk_i);
      strap <= 4'(i ^ 8);
      repeat (8) @(posedge clk_i);
      check(mode_now, {3'h0, strap[1], strap[0], strap[3], 8'h00, 1'b0, strap[2], 1'b1});
    end
    sel <= 1'b0;
    repeat (6) @(posedge clk_i);
    wr(`REG_SOFT_RESET_ADDR, 8'h80);
    modeck;
    $display("test straps done");
    for (int c = 0; c < 16; c++)
      samples((c < 8) ? 8'(c) : {2'($urandom), 3'(c), 3'($urandom)});
    for (int w = 0; w < 20 && q.size() > 0; w++)
      @(posedge clk_i);
    check(17'(q.size()), 17'h0_0000);
    $display("test samples done");
    end_sim;
  end
endmodule
